// File: hdl/apic_decode_shadow_port_select.v
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "apic_shadow_map.vh"
module apic_decode_shadow_port_select #(
	parameter ADDR_W = 10
) (
	input wire mclk,
	input wire arst_n,
	input wire ce,
	input wire [ADDR_W-1:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	input wire [15:10] pci_ad,
	input wire pci_addr_phase,
	input wire [7:0] shadow_data_in,
	output reg apic_cs,
	output reg [4:0] unit_select,
	output reg [4:0] port_select,
	output reg dma_view_valid,
	output reg [1:0] dma_channel,
	output reg [2:0] dma_field
);
	// Stored register state
	reg [6:0] apic_range;
	reg [7:0] shadow_sel;
	reg last_hit;
	reg [31:0] next_readdata;
	wire hit;
	wire [4:0] dec_unit;
	wire dec_valid;
	wire dec_dma_valid;
	wire [1:0] dec_dma_channel;
	wire [2:0] dec_dma_field;
	wire req;
	wire wr_take;

	// Word index of a byte address
	function [7:0] reg_index;
		input [ADDR_W-1:0] addr;
		begin
			reg_index = addr[9:2];
		end
	endfunction

	// True when the address hits the given index
	function is_reg;
		input [ADDR_W-1:0] addr;
		input [7:0] idx;
		begin
			is_reg = (reg_index(addr) == idx);
		end
	endfunction

	apic_range_match u_match (
		.range(apic_range),
		.pci_ad(pci_ad),
		.hit(hit)
	);

	shadow_port_decode u_decode (
		.sel(shadow_sel),
		.unit_onehot(dec_unit),
		.sel_valid(dec_valid),
		.dma_valid(dec_dma_valid),
		.dma_channel(dec_dma_channel),
		.dma_field(dec_dma_field)
	);

	assign req = read | write;
	// Write takes effect on the edge the master sees waitrequest low
	assign wr_take = write & ~waitrequest & byteenable[0];

	// Read value for the addressed register
	always @* begin
		next_readdata = 32'h00000000;
		if (is_reg(address, `IDX_APIC_RANGE)) begin
			next_readdata[6:0] = apic_range;
		end else if (is_reg(address, `IDX_SHADOW_SEL)) begin
			next_readdata[7:0] = shadow_sel;
		end else if (is_reg(address, `IDX_SHADOW_DATA)) begin
			// R10 zero on reserved
			next_readdata[7:0] = dec_valid ? shadow_data_in : 8'h00;
		end else if (is_reg(address, `IDX_STATUS)) begin
			next_readdata[1:0] = {dec_valid, last_hit};
		end
	end

	// Bus handshake: one wait cycle, then a single ready cycle
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else if (ce) begin
			if (waitrequest && req) begin
				waitrequest <= 1'b0;
				readdata <= next_readdata;
			end else begin
				waitrequest <= 1'b1;
			end
		end
	end

	// Register writes, low byte lane only
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			apic_range <= `RST_APIC_RANGE;
			// R4 selector reset
			shadow_sel <= `RST_SHADOW_SEL;
		end else if (ce && wr_take) begin
			if (is_reg(address, `IDX_APIC_RANGE)) begin
				apic_range <= writedata[6:0]; // Bit 7 reserved
			end
			// R4 selector write
			if (is_reg(address, `IDX_SHADOW_SEL)) begin
				shadow_sel <= writedata[7:0];
			end
		end
	end

	// Chip select, one cycle after each address phase that hits the range
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			apic_cs <= 1'b0;
			last_hit <= 1'b0;
		end else if (ce) begin
			// R11 assert only on match
			apic_cs <= pci_addr_phase & hit;
			if (pci_addr_phase) begin
				last_hit <= hit;
			end
		end
	end

	// Registered selector outputs toward the peripheral set
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			unit_select <= 5'h00;
			port_select <= 5'h00;
			dma_view_valid <= 1'b0;
			dma_channel <= 2'h0;
			dma_field <= `FLD_MODE;
		end else if (ce) begin
			// R5 unit strobes
			unit_select <= dec_unit;
			// R6 port field
			port_select <= dec_valid ? shadow_sel[`SEL_PORT_MSB:`SEL_PORT_LSB] : 5'h00;
			// R10 no strobe when reserved
			dma_view_valid <= dec_dma_valid;
			dma_channel <= dec_dma_channel;
			dma_field <= dec_dma_field;
		end
	end
endmodule // apic_decode_shadow_port_select
`default_nettype wire

// File: hdl/apic_shadow_map.vh
// Functional notes
// R1 - Range bits 5:2 match address bits 15:12 bit for bit.
// R2 - Range bits 1:0 match address bits 11:10 in the chip select decode.
// R3 - Range bit 6 set makes address bit 10 a don't care.
// R4 - Shadow selector resets to zero; upper field names unit, lower field names port.
// R5 - Unit codes: 1 timer, 2/3 master/slave interrupt, 4/5 master/slave DMA; rest reserved.
// R6 - Selector bits 4:0 pick one port of the selected unit.
// R7 - Master DMA ports 0 to 3 are channel 0 to 3 mode registers.
// R8 - Master DMA port 4 is request and mask combined.
// R9 - Master DMA ports 5 to 20 give four base bytes per channel; others reserved.
// R10 - Reserved unit or port codes read back zero and touch no peripheral.
// R11 - Chip select only when every enabled range bit matches the address.
`ifndef APIC_SHADOW_MAP_VH
`define APIC_SHADOW_MAP_VH
// Register indexes; byte address is four times the index
`define IDX_APIC_RANGE 8'h6c
`define IDX_RESERVED 8'h6d
`define IDX_SHADOW_SEL 8'h6e
`define IDX_SHADOW_DATA 8'h70
`define IDX_STATUS 8'h71
// Reset values
`define RST_APIC_RANGE 7'h00
`define RST_SHADOW_SEL 8'h00
// Range register fields
`define APIC_IGN10_BIT 6
`define APIC_HI_MSB 5
`define APIC_HI_LSB 2
// Selector fields
`define SEL_UNIT_MSB 7
`define SEL_UNIT_LSB 5
`define SEL_PORT_MSB 4
`define SEL_PORT_LSB 0
// Unit codes
`define UNIT_TIMER 3'h1
`define UNIT_INT_MASTER 3'h2
`define UNIT_INT_SLAVE 3'h3
`define UNIT_DMA_MASTER 3'h4
`define UNIT_DMA_SLAVE 3'h5
// Master DMA port codes
`define DMA_MODE_LAST 5'h03
`define DMA_REQ_MASK 5'h04
`define DMA_BASE_FIRST 5'h05
`define DMA_BASE_LAST 5'h14
// Master DMA field kinds
`define FLD_MODE 3'h0
`define FLD_REQ_MASK 3'h1
`define FLD_ADDR_LO 3'h2
`define FLD_ADDR_HI 3'h3
`define FLD_COUNT_LO 3'h4
`define FLD_COUNT_HI 3'h5
`endif

// File: hdl/apic_range_match.v
`timescale 1ns/1ps
`default_nettype none
`include "apic_shadow_map.vh"
module apic_range_match (
	input wire [6:0] range,
	input wire [15:10] pci_ad,
	output wire hit
);
	wire [3:0] hi_range;
	wire hi_ok;
	wire bit11_ok;
	wire bit10_ok;

	assign hi_range = range[`APIC_HI_MSB:`APIC_HI_LSB];
	// R1 upper nibble compare
	assign hi_ok = (hi_range == pci_ad[15:12]);
	// R2 low field compare
	assign bit11_ok = (range[1] == pci_ad[11]);
	// R3 bit ten masking
	assign bit10_ok = range[`APIC_IGN10_BIT] | (range[0] == pci_ad[10]);
	// R11 all enabled bits
	assign hit = hi_ok & bit11_ok & bit10_ok;
endmodule // apic_range_match
`default_nettype wire

// File: hdl/shadow_port_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "apic_shadow_map.vh"
module shadow_port_decode (
	input wire [7:0] sel,
	output reg [4:0] unit_onehot,
	output reg sel_valid,
	output reg dma_valid,
	output reg [1:0] dma_channel,
	output reg [2:0] dma_field
);
	reg [2:0] unit;
	reg [4:0] port;
	reg [4:0] off;

	// Unit and master DMA port decode
	always @* begin
		unit = sel[`SEL_UNIT_MSB:`SEL_UNIT_LSB];
		port = sel[`SEL_PORT_MSB:`SEL_PORT_LSB];
		off = port - `DMA_BASE_FIRST;
		unit_onehot = 5'h00;
		sel_valid = 1'b1;
		dma_valid = 1'b0;
		dma_channel = 2'h0;
		dma_field = `FLD_MODE;
		// R5 unit code decode
		case (unit)
			`UNIT_TIMER: unit_onehot = 5'h01;
			`UNIT_INT_MASTER: unit_onehot = 5'h02;
			`UNIT_INT_SLAVE: unit_onehot = 5'h04;
			`UNIT_DMA_MASTER: unit_onehot = 5'h08;
			`UNIT_DMA_SLAVE: unit_onehot = 5'h10;
			default: sel_valid = 1'b0;
		endcase
		if (unit == `UNIT_DMA_MASTER) begin
			// R7 mode registers
			if (port <= `DMA_MODE_LAST) begin
				dma_valid = 1'b1;
				dma_channel = port[1:0];
			// R8 request and mask
			end else if (port == `DMA_REQ_MASK) begin
				dma_valid = 1'b1;
				dma_field = `FLD_REQ_MASK;
			// R9 base byte groups
			end else if (port <= `DMA_BASE_LAST) begin
				dma_valid = 1'b1;
				dma_channel = off[3:2];
				dma_field = {1'b0, off[1:0]} + `FLD_ADDR_LO;
			end else begin
				// R10 reserved port code
				sel_valid = 1'b0;
				unit_onehot = 5'h00;
			end
		end
	end
endmodule // shadow_port_decode
`default_nettype wire

// File: verification/apic_sel_properties.sv
`timescale 1ns/1ps
`default_nettype none
module apic_sel_props #(
	parameter ADDR_W = 10
) (
	input wire mclk,
	input wire arst_n,
	input wire ce,
	input wire [ADDR_W-1:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire [15:10] pci_ad,
	input wire pci_addr_phase,
	input wire apic_cs,
	input wire [4:0] unit_select,
	input wire [4:0] port_select,
	input wire dma_view_valid,
	input wire [2:0] dma_field
);
	reg [6:0] rng;
	wire hit;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Range match against the shadowed range value
	assign hit = pci_ad[15:11] == rng[5:1] && (rng[6] || pci_ad[10] == rng[0]);
	// Shadow of the range register
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			rng <= 7'h00;
		else if (ce && write && !waitrequest && byteenable[0] && address == {8'h6c, 2'b00})
			rng <= writedata[6:0];
	end
	chk_cs_match: assert property (ce && pci_addr_phase |=> apic_cs == $past(hit))
		else $error("apic_cs differs from range match");
	chk_cs_idle: assert property (ce && !pci_addr_phase |=> !apic_cs)
		else $error("apic_cs without address phase");
	chk_wait_take: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered");
	chk_wait_pulse: assert property (ce && !waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	chk_ce_freeze: assert property (!ce |=> $stable(apic_cs) && $stable(waitrequest) && $stable(readdata) && $stable(unit_select))
		else $error("state moved while clock enable low");
	chk_unit_onehot: assert property ($onehot0(unit_select))
		else $error("unit_select not one-hot");
	chk_dma_unit: assert property (dma_view_valid |-> unit_select == 5'h08 && dma_field <= 3'h5)
		else $error("dma view outside master DMA");
	chk_rsvd_zero: assert property (unit_select == 5'h00 |-> port_select == 5'h00 && !dma_view_valid)
		else $error("reserved selection not cleared");
	chk_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	cover property (apic_cs);
	cover property (dma_view_valid);
	cover property (read && !waitrequest);
	cover property (pci_addr_phase && rng[6] && hit);
endmodule // apic_sel_props
bind apic_decode_shadow_port_select apic_sel_props #(.ADDR_W(ADDR_W)) i_apic_sel_props (
	.mclk(mclk), .arst_n(arst_n), .ce(ce), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .pci_ad(pci_ad), .pci_addr_phase(pci_addr_phase),
	.apic_cs(apic_cs), .unit_select(unit_select), .port_select(port_select),
	.dma_view_valid(dma_view_valid), .dma_field(dma_field));
`default_nettype wire

// File: verification/shadow_source.sv
`timescale 1ns/1ps
`default_nettype none
module shadow_source (
	input wire [4:0] unit_select,
	input wire [4:0] port_select,
	output wire [7:0] shadow_data_in
);
	// Byte names the selection; junk when nothing is selected
	assign shadow_data_in = unit_select == 5'h00 ? 8'ha5 : {port_select[2:0], unit_select};
endmodule // shadow_source
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk = 0;
	logic arst_n = 0;
	logic read = 0;
	logic write = 0;
	logic pci_addr_phase = 0;
	logic ce = 1;
	logic [9:0] address = 10'h000;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [15:10] pci_ad = 6'h00;
	logic [31:0] readdata, q;
	logic [7:0] sd;
	logic [4:0] unit_select, port_select, e5;
	logic [1:0] dma_channel;
	logic [2:0] dma_field;
	logic waitrequest, apic_cs, dma_view_valid;
	int error_cnt = 0, n_tests = 0, cyc = 0, u, p, ch, f;
	apic_decode_shadow_port_select i_apic_decode_shadow_port_select (.mclk(mclk),
		.arst_n(arst_n), .ce(ce), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .pci_ad(pci_ad), .pci_addr_phase(pci_addr_phase),
		.shadow_data_in(sd), .apic_cs(apic_cs), .unit_select(unit_select),
		.port_select(port_select), .dma_view_valid(dma_view_valid),
		.dma_channel(dma_channel), .dma_field(dma_field));
	shadow_source i_shadow_source (.unit_select(unit_select), .port_select(port_select),
		.shadow_data_in(sd));
	task results;
		$display("mismatches %0d of %0d checks", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Bus cycle held until waitrequest is sampled low
	task acc(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
		@(posedge mclk);
		read <= !w;
		write <= w;
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		byteenable <= be;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
		acc(1'b0, idx, 8'h00, 4'h0);
		cmp(nm, {24'h0, e}, q);
	endtask
	// One address phase, then the pulse is sampled
	task pci(input logic [15:10] ad, input logic e);
		@(posedge mclk);
		pci_ad <= ad;
		pci_addr_phase <= 1'b1;
		@(posedge mclk);
		pci_addr_phase <= 1'b0;
		@(posedge mclk);
		cmp("apic_cs", e, apic_cs);
	endtask
	initial forever #50 mclk = ~mclk;
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			results;
		end
	end
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		rd(8'h6e, 8'h00, "sel_reset");
		acc(1'b1, 8'h6c, 8'hff, 4'h1);
		rd(8'h6c, 8'h7f, "range");
		acc(1'b1, 8'h6c, 8'h00, 4'h0);
		rd(8'h6c, 8'h7f, "range_be");
		rd(8'h6d, 8'h00, "rsvd_idx");
		acc(1'b1, 8'h6c, 8'h2d, 4'h1);
		pci(6'h2d, 1'b1);
		pci(6'h2c, 1'b0);
		pci(6'h1d, 1'b0);
		pci(6'h29, 1'b0);
		pci(6'h2f, 1'b0);
		acc(1'b1, 8'h6c, 8'h6d, 4'h1);
		pci(6'h2c, 1'b1);
		rd(8'h71, 8'h01, "status");
		pci(6'h2e, 1'b0);
		// Clock enable low: a matching phase must not raise the chip select
		@(posedge mclk);
		ce <= 1'b0;
		pci(6'h2c, 1'b0);
		@(posedge mclk);
		ce <= 1'b1;
		for (u = 0; u < 8; u++) begin
			acc(1'b1, 8'h6e, {u[2:0], 5'h03}, 4'h1);
			e5 = (u > 0 && u < 6) ? 5'h01 << (u - 1) : 5'h00;
			rd(8'h70, e5 == 5'h00 ? 8'h00 : {3'h3, e5}, "shadow");
			cmp("unit", e5, unit_select);
			cmp("port", e5 == 5'h00 ? 5'h00 : 5'h03, port_select);
		end
		for (p = 0; p < 22; p++) begin
			acc(1'b1, 8'h6e, {3'h4, p[4:0]}, 4'h1);
			rd(8'h70, p < 21 ? {p[2:0], 5'h08} : 8'h00, "dma_data");
			ch = p < 4 ? p : p == 4 ? 0 : (p - 5) / 4;
			f = p < 4 ? 0 : p == 4 ? 1 : 2 + (p - 5) % 4;
			cmp("dma_ok", p < 21, dma_view_valid);
			if (p < 21) cmp("dma", {ch[1:0], f[2:0]}, {dma_channel, dma_field});
		end
		rd(8'h10, 8'h00, "unmapped");
		rd(8'h6e, 8'h95, "sel");
		// Second reset in mid-run returns the selector and its outputs to zero
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		cmp("unit_rst", 32'h0, unit_select);
		rd(8'h6e, 8'h00, "sel_rst");
		results;
	end
endmodule // tb_top
`default_nettype wire
